//--- shared/lec_pkg.sv
package lec_pkg;
  // Register byte offsets on the plain register port.
  localparam logic [7:0] LEC_OFF_ROM_MAP  = 8'h34;
  localparam logic [7:0] LEC_OFF_FAIL_LO  = 8'h38;
  localparam logic [7:0] LEC_OFF_FAIL_HI  = 8'h3c;
  localparam logic [7:0] LEC_OFF_VENDOR   = 8'h40;
  localparam logic [7:0] LEC_OFF_HC_SET   = 8'h50;
  localparam logic [7:0] LEC_OFF_HC_CLR   = 8'h54;
  localparam logic [7:0] LEC_OFF_IRQ_STAT = 8'h60;
  localparam logic [7:0] LEC_OFF_IRQ_MASK = 8'h64;

  // Field positions.
  localparam int LEC_IMAGE_VALID_BIT = 31;
  localparam int LEC_SRC_MSB         = 31;
  localparam int LEC_SRC_LSB         = 16;
  localparam int LEC_OFF_HI_MSB      = 15;
  localparam int LEC_MAP_LSB         = 10;
  localparam int LEC_EV_PW_FAIL      = 0;
  localparam int LEC_EV_FETCH_ERR    = 1;
  localparam int LEC_EV_TYPE_ERR     = 2;
  localparam int LEC_EV_COUNT        = 3;

  // Values after reset.
  localparam logic [31:0] LEC_FAIL_RST = 32'h0000_0000;
  localparam logic [31:0] LEC_MAP_RST  = 32'h0000_0000;
  localparam logic [2:0]  LEC_MASK_RST = 3'h0;
  localparam logic [2:0]  LEC_STAT_RST = 3'h0;

  // Arbitrary neutral extension code; it names no real maker.
  localparam logic [31:0] LEC_VENDOR_CODE = 32'h00c0_ffee;

  // Host memory address of a ROM window access: base plus low offset bits.
  function automatic logic [31:0] lec_rom_addr(input logic [31:0] base, input logic [9:0] offset);
    lec_rom_addr = base + {22'h000000, offset};
  endfunction
endpackage

//--- logic/lec_rom_gate.sv
`timescale 1ns/100ps
// Answers configuration ROM window reads; blocks depend on the image flag.
module lec_rom_gate
  import lec_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        soft_rst,
  // Gate controls.
  input  wire logic        image_valid,
  input  wire logic [31:0] map_base,
  // Request from the receive side.
  input  wire logic        rom_req,
  input  wire logic        rom_req_block,
  input  wire logic [9:0]  rom_req_offset,
  // Registered answer.
  output logic             rom_resp,
  output logic             rom_resp_type_error,
  output logic [31:0]      rom_resp_host_addr
);
  typedef struct packed {
    logic        resp;
    logic        type_err;
    logic [31:0] addr;
  } lec_gate_t;

  lec_gate_t s_reg;
  lec_gate_t s_next;

  // A block read without a valid image gets a type error and no address.
  always_comb begin
    s_next = '0;
    if (rom_req && !soft_rst) begin
      s_next.resp = 1'b1;
      if (rom_req_block && !image_valid) begin
        s_next.type_err = 1'b1;
      end else begin
        s_next.addr = lec_rom_addr(map_base, rom_req_offset);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rom_resp            = s_reg.resp;
  assign rom_resp_type_error = s_reg.type_err;
  assign rom_resp_host_addr  = s_reg.addr;
endmodule // lec_rom_gate

//--- logic/lec_top.sv
`timescale 1ns/100ps
module lec_top
  import lec_pkg::*;
#(
  parameter logic [31:0] VENDOR_CODE = LEC_VENDOR_CODE
)
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst,
  // Register port.
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Posted write failure report.
  input  wire logic        pw_fail,
  input  wire logic [15:0] pw_fail_source,
  input  wire logic [47:0] pw_fail_offset,
  // Link events and status.
  input  wire logic        soft_rst,
  input  wire logic        bus_reset,
  input  wire logic        bib_fetch_error,
  input  wire logic        link_active_gate,
  // Configuration ROM window requests.
  input  wire logic        rom_req,
  input  wire logic        rom_req_block,
  input  wire logic [9:0]  rom_req_offset,
  output logic             rom_resp,
  output logic             rom_resp_type_error,
  output logic [31:0]      rom_resp_host_addr,
  // Bus reset update strobe, flag and interrupt.
  output logic             rom_regs_update,
  output logic             image_valid_flag,
  output logic             irq
);
  import lec_pkg::*;

  typedef struct packed {
    logic [31:0]             fail_lo;
    logic [31:0]             fail_hi;
    logic [31:0]             map_next;
    logic [31:0]             map_active;
    logic                    image_valid;
    logic [LEC_EV_COUNT-1:0] stat;
    logic [LEC_EV_COUNT-1:0] mask;
    logic [31:0]             rdata;
    logic                    regs_update;
    logic                    irq;
  } lec_bank_t;

  localparam lec_bank_t LEC_BANK_RST = '{
    fail_lo:     LEC_FAIL_RST,
    fail_hi:     LEC_FAIL_RST,
    map_next:    LEC_MAP_RST,
    map_active:  LEC_MAP_RST,
    image_valid: 1'b0,
    stat:        LEC_STAT_RST,
    mask:        LEC_MASK_RST,
    rdata:       32'h0000_0000,
    regs_update: 1'b0,
    irq:         1'b0
  };

  lec_bank_t                s_reg;
  lec_bank_t                s_next;
  logic [LEC_EV_COUNT-1:0]  events;
  logic                     wr_set;
  logic                     wr_clr;

  // Address decode used by the writes; reads and checks compare reg_addr directly.
  function automatic logic lec_hit(input logic [7:0] addr, input logic [7:0] off);
    lec_hit = (addr == off);
  endfunction

  // Writes of one to bit 31 at either flag address; zero changes nothing.
  assign wr_set = reg_wr && lec_hit(reg_addr, LEC_OFF_HC_SET) && reg_wdata[LEC_IMAGE_VALID_BIT];
  assign wr_clr = reg_wr && lec_hit(reg_addr, LEC_OFF_HC_CLR) && reg_wdata[LEC_IMAGE_VALID_BIT];

  // Event sources for the sticky status bits.
  always_comb begin
    events                   = '0;
    events[LEC_EV_PW_FAIL]   = pw_fail;
    events[LEC_EV_FETCH_ERR] = bib_fetch_error;
    events[LEC_EV_TYPE_ERR]  = rom_resp && rom_resp_type_error;
  end

  // Next state of the whole bank.
  always_comb begin
    s_next             = s_reg;
    s_next.rdata       = 32'h0000_0000;
    s_next.regs_update = 1'b0;

    // A new failure overwrites the last one; software sees the most recent.
    if (pw_fail) begin
      s_next.fail_hi[LEC_SRC_MSB:LEC_SRC_LSB] = pw_fail_source;
      s_next.fail_hi[LEC_OFF_HI_MSB:0]        = pw_fail_offset[47:32];
      s_next.fail_lo                          = pw_fail_offset[31:0];
    end

    // Mapping writes go to a pending copy; it takes effect at bus reset.
    if (reg_wr && lec_hit(reg_addr, LEC_OFF_ROM_MAP)) begin
      s_next.map_next = {reg_wdata[31:LEC_MAP_LSB], 10'h000};
    end
    if (reg_wr && lec_hit(reg_addr, LEC_OFF_IRQ_MASK)) begin
      s_next.mask = reg_wdata[LEC_EV_COUNT-1:0];
    end

    // A set while the link is active is ignored, protecting a live image.
    if (wr_set && !link_active_gate) begin
      s_next.image_valid = 1'b1;
    end
    if (wr_clr) begin
      s_next.image_valid = 1'b0;
    end
    // A fetch error beats a software set in the same cycle.
    if (bib_fetch_error) begin
      s_next.image_valid = 1'b0;
    end

    // Without a valid image the ROM registers keep their old contents.
    if (bus_reset && s_reg.image_valid) begin
      s_next.map_active  = s_reg.map_next;
      s_next.regs_update = 1'b1;
    end

    // Write one to clear, but a new event in the same cycle wins.
    if (reg_wr && lec_hit(reg_addr, LEC_OFF_IRQ_STAT)) begin
      s_next.stat = s_reg.stat & ~reg_wdata[LEC_EV_COUNT-1:0];
    end
    s_next.stat = s_next.stat | events;
    s_next.irq  = |(s_next.stat & s_next.mask);

    // Read data appears in the cycle after the strobe.
    if (reg_rd) begin
      case (reg_addr)
        LEC_OFF_ROM_MAP:  s_next.rdata = s_reg.map_next;
        LEC_OFF_FAIL_LO:  s_next.rdata = s_reg.fail_lo;
        LEC_OFF_FAIL_HI:  s_next.rdata = s_reg.fail_hi;
        LEC_OFF_VENDOR:   s_next.rdata = VENDOR_CODE;
        LEC_OFF_HC_SET:   s_next.rdata = {s_reg.image_valid, 31'h0};
        LEC_OFF_HC_CLR:   s_next.rdata = {s_reg.image_valid, 31'h0};
        LEC_OFF_IRQ_STAT: s_next.rdata = {29'h0, s_reg.stat};
        LEC_OFF_IRQ_MASK: s_next.rdata = {29'h0, s_reg.mask};
        default:          s_next.rdata = 32'h0000_0000;
      endcase
    end

    // Software reset returns the bank to its reset image.
    if (soft_rst) begin
      s_next = LEC_BANK_RST;
    end
  end

  // State register.
  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= LEC_BANK_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs come straight from the bank register.
  assign reg_rdata        = s_reg.rdata;
  assign rom_regs_update  = s_reg.regs_update;
  assign image_valid_flag = s_reg.image_valid;
  assign irq              = s_reg.irq;

  // Window read gate; uses the mapping base already in effect.
  lec_rom_gate u_gate (
    .clock               (clock),
    .rst                 (rst),
    .soft_rst            (soft_rst),
    .image_valid         (s_reg.image_valid),
    .map_base            (s_reg.map_active),
    .rom_req             (rom_req),
    .rom_req_block       (rom_req_block),
    .rom_req_offset      (rom_req_offset),
    .rom_resp            (rom_resp),
    .rom_resp_type_error (rom_resp_type_error),
    .rom_resp_host_addr  (rom_resp_host_addr)
  );

  // Checks.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence seq_fail_report;
    pw_fail && !soft_rst;
  endsequence

  sequence seq_valid_set;
    wr_set && !link_active_gate && !wr_clr && !bib_fetch_error && !soft_rst;
  endsequence

  sequence seq_block_req(logic valid);
    rom_req && rom_req_block && !soft_rst && image_valid_flag == valid;
  endsequence

  chk_fail_hi_capture: assert property (
    seq_fail_report |=> s_reg.stat[LEC_EV_PW_FAIL] &&
    s_reg.fail_hi == {$past(pw_fail_source), $past(pw_fail_offset[47:32])})
    else $error("failure high capture mismatch");

  chk_fail_lo_capture: assert property (
    seq_fail_report |=> s_reg.fail_lo == $past(pw_fail_offset[31:0]))
    else $error("failure low capture mismatch");

  chk_vendor_read: assert property (
    reg_rd && reg_addr == LEC_OFF_VENDOR && !soft_rst |=> reg_rdata == VENDOR_CODE)
    else $error("vendor code read wrong");

  chk_flag_set_addr: assert property (
    seq_valid_set |=> image_valid_flag ##1 (reg_rdata[31] || !$past(reg_rd) || $past(soft_rst) ||
    ($past(reg_addr) != LEC_OFF_HC_SET && $past(reg_addr) != LEC_OFF_HC_CLR)))
    else $error("set address did not set flag");

  chk_flag_clear_addr: assert property (
    wr_clr |=> !image_valid_flag)
    else $error("clear address did not clear flag");

  chk_zero_write_idle: assert property (
    reg_wr && (reg_addr == LEC_OFF_HC_SET || reg_addr == LEC_OFF_HC_CLR) && !reg_wdata[31]
    && !bib_fetch_error && !soft_rst |=> $stable(image_valid_flag))
    else $error("zero write changed flag");

  chk_block_answer: assert property (
    seq_block_req(1'b1) |=> rom_resp && !rom_resp_type_error)
    else $error("valid block read not answered");

  chk_block_type_err: assert property (
    seq_block_req(1'b0) |=> rom_resp && rom_resp_type_error ##1 (s_reg.stat[LEC_EV_TYPE_ERR] || $past(soft_rst)))
    else $error("invalid block read not refused");

  chk_map_frozen: assert property (
    bus_reset && !image_valid_flag && !soft_rst |=> $stable(s_reg.map_active) && !rom_regs_update)
    else $error("ROM mapping changed without image");

  chk_gate_blocks_set: assert property (
    link_active_gate && !image_valid_flag |=> !image_valid_flag)
    else $error("flag set while link active");

  chk_fetch_clears: assert property (
    bib_fetch_error |=> !image_valid_flag ##1 !image_valid_flag || $past(wr_set))
    else $error("fetch error left flag set");

  chk_quadlet_addr: assert property (
    rom_req && !rom_req_block && !soft_rst |=>
    rom_resp && rom_resp_host_addr == lec_rom_addr($past(s_reg.map_active), $past(rom_req_offset)))
    else $error("quadlet host address wrong");

  chk_irq_level: assert property (
    pw_fail && s_reg.mask[LEC_EV_PW_FAIL] && !soft_rst && !(reg_wr && reg_addr == LEC_OFF_IRQ_MASK) |=> irq [*2] or
    (irq ##1 $past(reg_wr)) or (irq ##1 $past(soft_rst)))
    else $error("interrupt not raised for failure");

  // Register read data and capture hold checks; data must not leak outside the read slot.
  chk_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero when idle");

  chk_capture_holds: assert property (
    !pw_fail && !soft_rst |=>
    $stable(s_reg.fail_hi) && $stable(s_reg.fail_lo))
    else $error("capture changed without a failure");

  chk_soft_clears: assert property (
    soft_rst |=> !image_valid_flag && s_reg.fail_hi == LEC_FAIL_RST &&
    s_reg.stat == LEC_STAT_RST && reg_rdata == 32'h0000_0000)
    else $error("software reset left state behind");

  chk_map_write: assert property (
    reg_wr && reg_addr == LEC_OFF_ROM_MAP && !soft_rst |=>
    s_reg.map_next == {$past(reg_wdata[31:LEC_MAP_LSB]), 10'h000})
    else $error("mapping write not taken");

  chk_map_low_zero: assert property (
    reg_rd && reg_addr == LEC_OFF_ROM_MAP && !soft_rst |=>
    reg_rdata[LEC_MAP_LSB-1:0] == 10'h000)
    else $error("mapping low bits not zero");

  chk_flag_readback: assert property (
    reg_rd && (reg_addr == LEC_OFF_HC_SET || reg_addr == LEC_OFF_HC_CLR) && !soft_rst |=>
    reg_rdata == {$past(image_valid_flag), 31'h0000_0000})
    else $error("flag read back wrong");

  chk_flag_rise: assert property (
    $rose(image_valid_flag) |-> $past(wr_set) && !$past(link_active_gate))
    else $error("flag rose without a set write");

  // Interrupt status and mask checks.
  chk_stat_w1c: assert property (
    reg_wr && reg_addr == LEC_OFF_IRQ_STAT && reg_wdata[LEC_EV_PW_FAIL] && !pw_fail && !soft_rst |=>
    !s_reg.stat[LEC_EV_PW_FAIL])
    else $error("status bit not cleared by one");

  chk_stat_set_wins: assert property (
    bib_fetch_error && !soft_rst |=> s_reg.stat[LEC_EV_FETCH_ERR])
    else $error("fetch error not recorded");

  chk_mask_write: assert property (
    reg_wr && reg_addr == LEC_OFF_IRQ_MASK && !soft_rst |=>
    s_reg.mask == $past(reg_wdata[LEC_EV_COUNT-1:0]))
    else $error("mask write not taken");

  // Bus reset update checks.
  chk_update_loads: assert property (
    bus_reset && image_valid_flag && !soft_rst |=>
    rom_regs_update && s_reg.map_active == $past(s_reg.map_next))
    else $error("bus reset did not load mapping");

  chk_active_holds: assert property (
    !(bus_reset && image_valid_flag) && !soft_rst |=> $stable(s_reg.map_active))
    else $error("active mapping changed without update");

  chk_update_pulse: assert property (
    rom_regs_update |=> !rom_regs_update || $past(bus_reset))
    else $error("update strobe stood too long");

  // Window answer timing checks.
  chk_resp_follows: assert property (
    rom_req && !soft_rst |=> rom_resp)
    else $error("window request not answered");

  chk_resp_idle: assert property (
    !rom_req || soft_rst |=> !rom_resp)
    else $error("answer without a request");

  chk_type_err_addr: assert property (
    rom_resp_type_error |-> rom_resp && rom_resp_host_addr == 32'h0000_0000)
    else $error("refused answer carries an address");

  chk_quadlet_ok: assert property (
    rom_req && !rom_req_block && !soft_rst |=> !rom_resp_type_error)
    else $error("quadlet read refused");
endmodule // lec_top

//--- sim/lec_node_model.sv
`timescale 1ns/100ps
// Remote node that reads the configuration ROM window, one request at a time.
module lec_node_model (
  // Clock.
  clock,
  // Request toward the window.
  rom_req,
  rom_req_block,
  rom_req_offset,
  // Answer from the window.
  rom_resp,
  rom_resp_type_error,
  rom_resp_host_addr
);
  input  wire logic        clock;
  output logic             rom_req;
  output logic             rom_req_block;
  output logic [9:0]       rom_req_offset;
  input  wire logic        rom_resp;
  input  wire logic        rom_resp_type_error;
  input  wire logic [31:0] rom_resp_host_addr;

  // Idle at time zero.
  initial begin
    rom_req = 1'b0;
    rom_req_block = 1'b0;
    rom_req_offset = 10'h000;
  end

  // Fields flip once released, so a stale offset can never pass for a held one.
  task automatic read(input logic blk, input logic [9:0] off, output logic rsp, output logic terr,
                      output logic [31:0] addr);
    @(posedge clock);
    rom_req <= 1'b1;
    rom_req_block <= blk;
    rom_req_offset <= off;
    @(posedge clock);
    rom_req <= 1'b0;
    rom_req_block <= ~blk;
    rom_req_offset <= ~off;
    #1;
    rsp = rom_resp;
    terr = rom_resp_type_error;
    addr = rom_resp_host_addr;
  endtask
endmodule // lec_node_model

//--- sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  import lec_pkg::*;
  // Bench signals.
  logic        clock, rst, reg_wr, reg_rd, pw_fail, soft_rst, bus_reset, bib_fetch_error, link_active_gate;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rom_resp_host_addr, seed, base, ha;
  logic [15:0] pw_fail_source, src;
  logic [47:0] pw_fail_offset, off;
  logic [9:0]  rom_req_offset, ro;
  logic        rom_req, rom_req_block, rom_resp, rom_resp_type_error, rom_regs_update, image_valid_flag, irq, rs, te;
  int          err_count, checked, cyc;
  logic [7:0]  zoff [8] = '{8'h3c, 8'h38, 8'h34, 8'h50, 8'h54, 8'h60, 8'h64, 8'h44};

  lec_top i_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pw_fail(pw_fail), .pw_fail_source(pw_fail_source),
    .pw_fail_offset(pw_fail_offset), .soft_rst(soft_rst), .bus_reset(bus_reset),
    .bib_fetch_error(bib_fetch_error), .link_active_gate(link_active_gate), .rom_req(rom_req),
    .rom_req_block(rom_req_block), .rom_req_offset(rom_req_offset), .rom_resp(rom_resp),
    .rom_resp_type_error(rom_resp_type_error), .rom_resp_host_addr(rom_resp_host_addr),
    .rom_regs_update(rom_regs_update), .image_valid_flag(image_valid_flag), .irq(irq));
  lec_node_model i_node (.clock(clock), .rom_req(rom_req), .rom_req_block(rom_req_block),
    .rom_req_offset(rom_req_offset), .rom_resp(rom_resp), .rom_resp_type_error(rom_resp_type_error),
    .rom_resp_host_addr(rom_resp_host_addr));

  // Free running clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Repeatable pseudo random source.
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // Expected capture-high word: requester id over the top offset bits.
  function automatic logic [31:0] exp_hi(input logic [15:0] s, input logic [47:0] o);
    return {s[15:6], s[5:0], o[47:32]};
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), reg_rdata, e);
  endtask

  // One-cycle event: 0 write failure, 1 bus reset, 2 fetch error, 3 soft reset.
  task automatic ev(input int k);
    @(posedge clock);
    pw_fail <= (k == 0);
    bus_reset <= (k == 1);
    bib_fetch_error <= (k == 2);
    soft_rst <= (k == 3);
    @(posedge clock);
    {pw_fail, bus_reset, bib_fetch_error, soft_rst} <= 4'h0;
    #1;
  endtask

  // A hang is cut short well past the length of the sequence.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    {rst, reg_wr, reg_rd, pw_fail, soft_rst, bus_reset, bib_fetch_error, link_active_gate} = 8'h80;
    {reg_addr, reg_wdata, pw_fail_source, pw_fail_offset} = '0;
    seed = 32'hd473;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(zoff[i], 32'h0);
    wr(LEC_OFF_VENDOR, rnd());
    rd(LEC_OFF_VENDOR, LEC_VENDOR_CODE);
    $display("test reset done");

    wr(LEC_OFF_IRQ_MASK, 32'h1);
    for (int i = 0; i < 3; i++) begin
      src = (i == 2) ? 16'hffff : 16'(rnd());
      off = (i == 2) ? 48'h8000_0000_0001 : 48'({rnd(), rnd()});
      pw_fail_source <= src;
      pw_fail_offset <= off;
      ev(0);
      pw_fail_source <= ~src;
      pw_fail_offset <= ~off;
      wr(LEC_OFF_FAIL_HI, rnd());
      rd(LEC_OFF_FAIL_HI, exp_hi(src, off));
      rd(LEC_OFF_FAIL_LO, off[31:0]);
      chk("irq", {31'h0, irq}, 32'h1);
    end
    wr(LEC_OFF_IRQ_STAT, 32'h1);
    rd(LEC_OFF_IRQ_STAT, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("test capture done");

    base = rnd();
    wr(LEC_OFF_ROM_MAP, base);
    base = base & 32'hffff_fc00;
    rd(LEC_OFF_ROM_MAP, base);
    ev(1);
    chk("update", {31'h0, rom_regs_update}, 32'h0);
    i_node.read(1'b1, 10'h004, rs, te, ha);
    chk("type error", {30'h0, rs, te}, 32'h3);
    rd(LEC_OFF_IRQ_STAT, 32'h4);
    ro = 10'(rnd());
    i_node.read(1'b0, ro, rs, te, ha);
    chk("quadlet addr", ha, {22'h0, ro});
    $display("test invalid image done");

    link_active_gate <= 1'b1;
    wr(LEC_OFF_HC_SET, 32'h8000_0000);
    rd(LEC_OFF_HC_SET, 32'h0);
    link_active_gate <= 1'b0;
    wr(LEC_OFF_HC_SET, 32'h7fff_ffff);
    rd(LEC_OFF_HC_SET, 32'h0);
    wr(LEC_OFF_HC_SET, 32'h8000_0000);
    rd(LEC_OFF_HC_CLR, 32'h8000_0000);
    wr(LEC_OFF_HC_CLR, 32'h0);
    chk("flag", {31'h0, image_valid_flag}, 32'h1);
    ev(1);
    chk("update", {31'h0, rom_regs_update}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      ro = (i == 3) ? 10'h3ff : 10'(rnd());
      i_node.read(i[0], ro, rs, te, ha);
      chk("block ok", {30'h0, rs, te}, 32'h2);
      chk("host addr", ha, base + {22'h0, ro});
    end
    wr(LEC_OFF_HC_CLR, 32'h8000_0000);
    rd(LEC_OFF_HC_SET, 32'h0);
    $display("test valid image done");

    for (int k = 2; k < 5; k++) begin
      wr(LEC_OFF_HC_SET, 32'h8000_0000);
      if (k < 4) ev(k);
      else begin
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        #1;
      end
      chk("flag cleared", {31'h0, image_valid_flag}, 32'h0);
    end
    rd(LEC_OFF_FAIL_HI, 32'h0);
    $display("test flag clear done");
    wrap_up();
  end
endmodule // testbench
